/* File: core/poee_defs.svh */
// register addresses, field positions and reset values of the event-enable block
`ifndef POEE_DEFS_SVH
`define POEE_DEFS_SVH
`define POEE_ADDR_OTG_W      6'h0A
`define POEE_ADDR_OTG_S      6'h0B
`define POEE_ADDR_OTG_C      6'h0C
`define POEE_ADDR_RISE_W     6'h0D
`define POEE_ADDR_RISE_S     6'h0E
`define POEE_ADDR_RISE_C     6'h0F
`define POEE_ADDR_FALL_W     6'h10
`define POEE_ADDR_FALL_S     6'h11
`define POEE_ADDR_FALL_C     6'h12
`define POEE_ADDR_STAT       6'h13
`define POEE_ADDR_LATCH      6'h14
`define POEE_NSRC            5
`define POEE_BIT_ID_GROUNDED      4
`define POEE_BIT_SESSION_ENDED    3
`define POEE_BIT_SESS_VALID  2
`define POEE_BIT_VBUS_VALID  1
`define POEE_BIT_HOST_DISC   0
`define POEE_BIT_DM_PD       2
`define POEE_BIT_DP_PD       1
`define POEE_BIT_ID_PU       0
`define POEE_EN_RESET        8'h1F
`define POEE_OTG_RESET       8'h06
`define POEE_SRC_MASK        8'h1F
`define POEE_ZERO_BYTE       8'h00
`endif

/* File: core/poee_pkg.sv */
// types shared by the event-enable block
package poee_pkg;
  typedef enum logic [1:0] {
    POEE_OP_NONE  = 2'b00,
    POEE_OP_WRITE = 2'b01,
    POEE_OP_SET   = 2'b10,
    POEE_OP_CLEAR = 2'b11
  } poee_op_type;
endpackage

/* File: core/poee_sync.sv */
// two-flop synchroniser for the analogue status sources
`timescale 1ns/1ns
module poee_sync (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic [4:0] async_in,
  output logic      [4:0] sync_out
);
  logic [4:0] stage1;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stage1   <= 5'h00;
      sync_out <= 5'h00;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

/* File: core/poee_regbyte.sv */
// one byte register with write, set and clear access
`timescale 1ns/1ns
`include "poee_defs.svh"
module poee_regbyte #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] KEEP_MASK = 8'hFF
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire poee_pkg::poee_op_type op,
  input  wire logic [7:0]           wdata,
  output logic      [7:0]           value
);
  logic [7:0] next_value;
  // write replaces, set ors in, clear removes ones
  assign next_value = (op == poee_pkg::POEE_OP_WRITE) ? (wdata & KEEP_MASK) :
                      (op == poee_pkg::POEE_OP_SET)   ? ((value | wdata) & KEEP_MASK) :
                      (op == poee_pkg::POEE_OP_CLEAR) ? (value & ~wdata) : value;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      value <= RESET_VAL;
    end else begin
      value <= next_value;
    end
  end
endmodule

/* File: core/poee_top.sv */
// otg event-enable registers, edge detection and termination control
//
// Behaviour
// - minus-line pull-down connected while control bit 2 is one, else open
// - plus-line pull-down connected while control bit 1 is one, else open
// - control bit 0 drives the id line pull-up
// - enabled rising source change raises interrupt and rxcmd request, else ignored
// - enabled falling source change raises interrupt and rxcmd request, else ignored
// - rise enables: bit4 id, 3 session_ended, 2 sess valid, 1 vbus, 0 disc
// - fall enables use the same mapping, bits 7 to 5 reserved
// - all five enables reset to one, reserved bits reset to zero
// - rise enable read at 0Dh-0Fh, write 0Dh, set 0Eh, clear 0Fh
// - fall enable read at 10h-12h, write 10h, set 11h, clear 12h
// - status at 13h shows present source values, same positions
// - latch at 14h sets on enabled change, clears on read or low power
`timescale 1ns/1ns
`include "poee_defs.svh"
module poee_top (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       low_power,
  input  wire logic       id_grounded,
  input  wire logic       session_ended,
  input  wire logic       session_valid_cmp,
  input  wire logic       vbus_valid_cmp,
  input  wire logic       host_disconnect_det,
  output logic      [7:0] reg_rdata,
  output logic            event_irq,
  output logic            rxcmd_req,
  output logic      [4:0] rxcmd_status,
  output logic            minus_line_pulldown_en,
  output logic            plus_line_pulldown_en,
  output logic            id_line_pullup_en
);
  //----------------------------------------------------------------
  // source synchronisation and edge detection
  //----------------------------------------------------------------
  logic [4:0] src_async;
  logic [4:0] src_sync;
  logic [4:0] src_prev;
  logic [4:0] rise_evt;
  logic [4:0] fall_evt;
  logic [4:0] hit;
  logic       any_hit;

  // status bit order, id ground on top
  assign src_async = {id_grounded, session_ended, session_valid_cmp,
                      vbus_valid_cmp, host_disconnect_det};

  poee_sync u_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .async_in (src_async),
    .sync_out (src_sync)
  );

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      src_prev <= 5'h00;
    end else begin
      src_prev <= src_sync;
    end
  end

  //----------------------------------------------------------------
  // register access decode
  //----------------------------------------------------------------
  poee_pkg::poee_op_type op_otg;
  poee_pkg::poee_op_type op_rise;
  poee_pkg::poee_op_type op_fall;
  logic [7:0] otg_termination_control;
  logic [7:0] rise_event_enable;
  logic [7:0] fall_event_enable;
  logic [7:0] source_latch_reg;
  logic [7:0] next_rdata;
  logic [4:0] next_latch;
  logic       latch_read;

  assign op_otg  = !reg_wr                           ? poee_pkg::POEE_OP_NONE :
                   (reg_addr == `POEE_ADDR_OTG_W)    ? poee_pkg::POEE_OP_WRITE :
                   (reg_addr == `POEE_ADDR_OTG_S)    ? poee_pkg::POEE_OP_SET :
                   (reg_addr == `POEE_ADDR_OTG_C)    ? poee_pkg::POEE_OP_CLEAR :
                                                       poee_pkg::POEE_OP_NONE;
  assign op_rise = !reg_wr                           ? poee_pkg::POEE_OP_NONE :
                   (reg_addr == `POEE_ADDR_RISE_W)   ? poee_pkg::POEE_OP_WRITE :
                   (reg_addr == `POEE_ADDR_RISE_S)   ? poee_pkg::POEE_OP_SET :
                   (reg_addr == `POEE_ADDR_RISE_C)   ? poee_pkg::POEE_OP_CLEAR :
                                                       poee_pkg::POEE_OP_NONE;
  assign op_fall = !reg_wr                           ? poee_pkg::POEE_OP_NONE :
                   (reg_addr == `POEE_ADDR_FALL_W)   ? poee_pkg::POEE_OP_WRITE :
                   (reg_addr == `POEE_ADDR_FALL_S)   ? poee_pkg::POEE_OP_SET :
                   (reg_addr == `POEE_ADDR_FALL_C)   ? poee_pkg::POEE_OP_CLEAR :
                                                       poee_pkg::POEE_OP_NONE;

  poee_regbyte #(.RESET_VAL(`POEE_OTG_RESET), .KEEP_MASK(8'hFF)) u_otg (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .op      (op_otg),
    .wdata   (reg_wdata),
    .value   (otg_termination_control)
  );

  // five enables reset to one, reserved bits held at zero
  poee_regbyte #(.RESET_VAL(`POEE_EN_RESET), .KEEP_MASK(`POEE_SRC_MASK)) u_rise (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .op      (op_rise),
    .wdata   (reg_wdata),
    .value   (rise_event_enable)
  );

  poee_regbyte #(.RESET_VAL(`POEE_EN_RESET), .KEEP_MASK(`POEE_SRC_MASK)) u_fall (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .op      (op_fall),
    .wdata   (reg_wdata),
    .value   (fall_event_enable)
  );

  //----------------------------------------------------------------
  // per-source enabled events
  //----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `POEE_NSRC; gi = gi + 1) begin : g_src
      assign rise_evt[gi] = src_sync[gi] & ~src_prev[gi];
      assign fall_evt[gi] = ~src_sync[gi] & src_prev[gi];
      assign hit[gi]      = (rise_evt[gi] & rise_event_enable[gi]) |
                            (fall_evt[gi] & fall_event_enable[gi]);
    end
  endgenerate
  assign any_hit = |hit;

  //----------------------------------------------------------------
  // latch, read data and outputs
  //----------------------------------------------------------------
  assign latch_read = reg_rd && (reg_addr == `POEE_ADDR_LATCH);
  // new events win over the read clear
  assign next_latch = (low_power ? 5'h00 :
                       (latch_read ? 5'h00 : source_latch_reg[4:0])) | hit;

  assign next_rdata =
    (reg_addr >= `POEE_ADDR_OTG_W  && reg_addr <= `POEE_ADDR_OTG_C)  ? otg_termination_control :
    (reg_addr >= `POEE_ADDR_RISE_W && reg_addr <= `POEE_ADDR_RISE_C) ? rise_event_enable :
    (reg_addr >= `POEE_ADDR_FALL_W && reg_addr <= `POEE_ADDR_FALL_C) ? fall_event_enable :
    (reg_addr == `POEE_ADDR_STAT)  ? {3'h0, src_sync} :
    (reg_addr == `POEE_ADDR_LATCH) ? source_latch_reg : `POEE_ZERO_BYTE;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      source_latch_reg       <= 8'h00;
      reg_rdata              <= 8'h00;
      event_irq              <= 1'b0;
      rxcmd_req              <= 1'b0;
      rxcmd_status           <= 5'h00;
      minus_line_pulldown_en <= 1'b0;
      plus_line_pulldown_en  <= 1'b0;
      id_line_pullup_en      <= 1'b0;
    end else begin
      source_latch_reg       <= {3'h0, next_latch};
      reg_rdata              <= reg_rd ? next_rdata : reg_rdata;
      event_irq              <= any_hit;
      rxcmd_req              <= any_hit;
      rxcmd_status           <= any_hit ? src_sync : rxcmd_status;
      minus_line_pulldown_en <= otg_termination_control[`POEE_BIT_DM_PD];
      plus_line_pulldown_en  <= otg_termination_control[`POEE_BIT_DP_PD];
      id_line_pullup_en      <= otg_termination_control[`POEE_BIT_ID_PU];
    end
  end

  //----------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------
  a_rise_event_report: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rise_evt[`POEE_BIT_VBUS_VALID] && rise_event_enable[`POEE_BIT_VBUS_VALID])
      |=> (rxcmd_req && event_irq))
    else $error("enabled rising change not reported");
  a_rise_masked_ignore: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rise_evt != 5'h00 && (rise_evt & rise_event_enable[4:0]) == 5'h00 &&
     (fall_evt & fall_event_enable[4:0]) == 5'h00) |=> !rxcmd_req)
    else $error("masked change was reported");
  a_fall_event_report: assert property (@(posedge ref_clk) disable iff (!rstn)
    (fall_evt[`POEE_BIT_ID_GROUNDED] && fall_event_enable[`POEE_BIT_ID_GROUNDED])
      |=> (rxcmd_req && !rxcmd_status[`POEE_BIT_ID_GROUNDED]))
    else $error("enabled falling change not reported");
  a_enable_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rise_event_enable[7:5] == 3'h0) && (fall_event_enable[7:5] == 3'h0))
    else $error("reserved enable bits not zero");
  a_enable_reset_ones: assert property (@(posedge ref_clk)
    (rstn && $past(!rstn)) |-> (rise_event_enable == `POEE_EN_RESET &&
                               fall_event_enable == `POEE_EN_RESET))
    else $error("enables not one after reset");
  a_set_access_or: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_wr && reg_addr == `POEE_ADDR_RISE_S)
      |=> ((rise_event_enable[4:0] & $past(reg_wdata[4:0])) == $past(reg_wdata[4:0])))
    else $error("set access did not set bits");
  a_clear_access_and: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_wr && reg_addr == `POEE_ADDR_FALL_C)
      |=> ((fall_event_enable & $past(reg_wdata)) == 8'h00))
    else $error("clear access left bits set");
  a_latch_on_event: assert property (@(posedge ref_clk) disable iff (!rstn)
    any_hit |=> (source_latch_reg[4:0] & $past(hit)) == $past(hit))
    else $error("latch missed an event");
  a_latch_low_power: assert property (@(posedge ref_clk) disable iff (!rstn)
    (low_power && !any_hit) |=> source_latch_reg == 8'h00)
    else $error("latch not cleared in low power");
  a_pulldown_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
    1'b1 |=> minus_line_pulldown_en == $past(otg_termination_control[`POEE_BIT_DM_PD]))
    else $error("minus pull-down not following control");
  a_plus_pulldown_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
    1'b1 |=> plus_line_pulldown_en == $past(otg_termination_control[`POEE_BIT_DP_PD]))
    else $error("plus pull-down not following control");
  a_id_line_pullup_en_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
    1'b1 |=> id_line_pullup_en == $past(otg_termination_control[`POEE_BIT_ID_PU]))
    else $error("id pull-up not following control");

  //----------------------------------------------------------------
  // event assertions
  //----------------------------------------------------------------
  a_rise_any_report: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rise_evt & rise_event_enable[4:0]) != 5'h00
      |=> (event_irq && rxcmd_req))
    else $error("enabled rising change missed");
  a_fall_any_report: assert property (@(posedge ref_clk) disable iff (!rstn)
    (fall_evt & fall_event_enable[4:0]) != 5'h00
      |=> (event_irq && rxcmd_req))
    else $error("enabled falling change missed");
  a_fall_masked_ignore: assert property (@(posedge ref_clk) disable iff (!rstn)
    (fall_evt != 5'h00 && (fall_evt & fall_event_enable[4:0]) == 5'h00 &&
     (rise_evt & rise_event_enable[4:0]) == 5'h00) |=> !event_irq)
    else $error("masked falling change was reported");
  a_no_hit_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
    !any_hit |=> (!event_irq && !rxcmd_req))
    else $error("report without enabled change");
  a_status_capture: assert property (@(posedge ref_clk) disable iff (!rstn)
    any_hit |=> rxcmd_status == $past(src_sync))
    else $error("rxcmd status not captured");
  a_status_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    !any_hit |=> $stable(rxcmd_status))
    else $error("rxcmd status changed without event");
  a_edge_detect: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(rstn) |-> (rise_evt | fall_evt) == (src_sync ^ $past(src_sync)))
    else $error("change detection wrong");

  //----------------------------------------------------------------
  // register access assertions
  //----------------------------------------------------------------
  a_rise_write_replace: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_wr && reg_addr == `POEE_ADDR_RISE_W)
      |=> rise_event_enable == ($past(reg_wdata) & `POEE_SRC_MASK))
    else $error("rise write did not replace");
  a_fall_write_replace: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_wr && reg_addr == `POEE_ADDR_FALL_W)
      |=> fall_event_enable == ($past(reg_wdata) & `POEE_SRC_MASK))
    else $error("fall write did not replace");
  a_fall_set_or: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_wr && reg_addr == `POEE_ADDR_FALL_S)
      |=> ((fall_event_enable[4:0] & $past(reg_wdata[4:0])) == $past(reg_wdata[4:0])))
    else $error("fall set did not set bits");
  a_rise_clear_and: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_wr && reg_addr == `POEE_ADDR_RISE_C)
      |=> ((rise_event_enable & $past(reg_wdata)) == `POEE_ZERO_BYTE))
    else $error("rise clear left bits set");
  a_otg_write_replace: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_wr && reg_addr == `POEE_ADDR_OTG_W)
      |=> otg_termination_control == $past(reg_wdata))
    else $error("control write did not replace");
  a_otg_set_or: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_wr && reg_addr == `POEE_ADDR_OTG_S)
      |=> ((otg_termination_control & $past(reg_wdata)) == $past(reg_wdata)))
    else $error("control set did not set bits");
  a_otg_clear_and: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_wr && reg_addr == `POEE_ADDR_OTG_C)
      |=> ((otg_termination_control & $past(reg_wdata)) == `POEE_ZERO_BYTE))
    else $error("control clear left bits set");
  a_rise_read_alias: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_rd && reg_addr >= `POEE_ADDR_RISE_W && reg_addr <= `POEE_ADDR_RISE_C)
      |=> reg_rdata == $past(rise_event_enable))
    else $error("rise enable read wrong");
  a_fall_read_alias: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_rd && reg_addr >= `POEE_ADDR_FALL_W && reg_addr <= `POEE_ADDR_FALL_C)
      |=> reg_rdata == $past(fall_event_enable))
    else $error("fall enable read wrong");
  a_rdata_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");

  //----------------------------------------------------------------
  // status and latch assertions
  //----------------------------------------------------------------
  a_status_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_rd && reg_addr == `POEE_ADDR_STAT)
      |=> reg_rdata == {3'h0, $past(src_sync)})
    else $error("status read wrong");
  a_latch_read_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    (latch_read && !any_hit) |=> source_latch_reg == `POEE_ZERO_BYTE)
    else $error("latch not cleared by read");
endmodule

/* File: tb/poee_link_model.sv */
// link-side model that collects rxcmds sent by the phy
`timescale 1ns/1ns
module poee_link_model (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       rxcmd_req,
  input  wire logic       event_irq,
  input  wire logic [4:0] rxcmd_status,
  output logic      [7:0] rxcmd_count,
  output logic      [4:0] last_status
);
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rxcmd_count <= 8'h00;
      last_status <= 5'h00;
    end else if (rxcmd_req && event_irq) begin
      rxcmd_count <= rxcmd_count + 8'h01;
      last_status <= rxcmd_status;
    end
  end
endmodule

/* File: tb/phy_otg_event_enable_tb.sv */
// self-checking bench for the otg event-enable block
`timescale 1ns/1ns
module phy_otg_event_enable_tb;
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       low_power = 1'b0;
  logic [4:0] src = 5'h00;
  logic [7:0] reg_rdata;
  logic       event_irq;
  logic       rxcmd_req;
  logic [4:0] rxcmd_status;
  logic [2:0] pins;
  logic [7:0] link_cnt;
  logic [4:0] link_status;
  int         failures = 0;
  int         checks = 0;
  int         cycles = 0;
  int         irq_cnt = 0;

  poee_top dut (.ref_clk(ref_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .low_power(low_power),
    .id_grounded(src[4]), .session_ended(src[3]), .session_valid_cmp(src[2]),
    .vbus_valid_cmp(src[1]), .host_disconnect_det(src[0]), .reg_rdata(reg_rdata),
    .event_irq(event_irq), .rxcmd_req(rxcmd_req), .rxcmd_status(rxcmd_status),
    .minus_line_pulldown_en(pins[2]), .plus_line_pulldown_en(pins[1]),
    .id_line_pullup_en(pins[0]));

  poee_link_model link (.ref_clk(ref_clk), .rstn(rstn), .rxcmd_req(rxcmd_req),
    .event_irq(event_irq), .rxcmd_status(rxcmd_status), .rxcmd_count(link_cnt),
    .last_status(link_status));

  always #4 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles++;
    if (event_irq === 1'b1) irq_cnt++;
    if (cycles == 3000) begin
      failures++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, exp);
  endtask

  task automatic drive_src(input logic [4:0] v, input logic [7:0] n);
    int         base;
    logic [7:0] lbase;
    base = irq_cnt;
    lbase = link_cnt;
    @(negedge ref_clk);
    src = v;
    repeat (8) @(negedge ref_clk);
    chk(8'(irq_cnt - base), n);
    chk(link_cnt - lbase, n);
    if (n != 8'h00) chk({3'b000, link_status}, {3'b000, v});
  endtask

  initial begin
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    for (int a = 13; a <= 18; a++) rd(6'(a), 8'h1F);
    rd(6'h0A, 8'h06);
    rd(6'h3F, 8'h00);
    chk({5'h00, pins}, 8'h06);
    wr(6'h0D, 8'hA5);
    rd(6'h0D, 8'h05);
    wr(6'h0E, 8'h18);
    rd(6'h0F, 8'h1D);
    wr(6'h0F, 8'h05);
    rd(6'h0E, 8'h18);
    wr(6'h10, 8'hE0);
    rd(6'h12, 8'h00);
    wr(6'h11, 8'h03);
    rd(6'h10, 8'h03);
    wr(6'h12, 8'h01);
    rd(6'h11, 8'h02);
    wr(6'h0C, 8'h06);
    wr(6'h0B, 8'h01);
    @(negedge ref_clk);
    chk({5'h00, pins}, 8'h01);
    wr(6'h0A, 8'h04);
    @(negedge ref_clk);
    chk({5'h00, pins}, 8'h04);
    for (int i = 0; i < 5; i++) begin
      wr(6'h0D, 8'(1 << i));
      wr(6'h10, 8'h00);
      drive_src(5'(1 << i), 8'h01);
      rd(6'h13, 8'(1 << i));
      rd(6'h14, 8'(1 << i));
      rd(6'h14, 8'h00);
      drive_src(5'h00, 8'h00);
      wr(6'h0D, 8'h00);
      wr(6'h11, 8'(1 << i));
      drive_src(5'(1 << i), 8'h00);
      drive_src(5'h00, 8'h01);
      rd(6'h14, 8'(1 << i));
    end
    wr(6'h0D, 8'h1F);
    drive_src(5'h1F, 8'h01);
    @(negedge ref_clk);
    low_power = 1'b1;
    repeat (2) @(negedge ref_clk);
    low_power = 1'b0;
    rd(6'h14, 8'h00);
    final_report();
  end
endmodule
